// *** hdl/lcdc_cmd_decoder.sv ***
// Purpose: host command decoder of a graphics lcd controller
// Assumes: host strobes are one-cycle pulses synchronous to sys_clk
// Notes:   vram_rdata is valid in the cycle of a host read strobe
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_consts.svh"

// Operation
// - command byte written with select high; 0x40 is setup with eight parameters
// - 0x58/0x59 display enable, opcode bit 0 is on/off, one parameter
// - 0x44 screen start and region setup, ten parameters
// - 0x5c sets character ram base address, two parameters
// - 0x4c-0x4f cursor direction from low opcode bits, no parameters
// - 0x5a horizontal pixel scroll, one parameter
// - 0x5b layer overlay mode, one parameter
// - cursor address write/read 0x46/0x47 handle each byte separately
// - 0x42 vram write, following data bytes go to display memory
// - 0x43 vram read, host reads memory, no fixed parameter count
// - screen and char ram pairs commit together; lone low byte dropped
// - each parameter within the command's count, except a screen or char ram pair low byte, updates its setting register on arrival; extra ones are dropped
// - new command early keeps written values, unsent ones unchanged
// - pitch low and high bytes commit independently
module lcdc_cmd_decoder #(
  parameter int ADDR_W = 16
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                host_wr,
  input  wire logic                host_rd,
  input  wire logic                cmd_param_select,
  input  wire logic [7:0]          host_wdata,
  input  wire logic [7:0]          vram_rdata,
  output logic      [7:0]          host_rdata,
  output logic                     host_rvalid,
  output logic      [ADDR_W-1:0]   vram_addr,
  output logic      [7:0]          vram_wdata,
  output logic                     vram_we,
  output logic                     standby,
  output logic                     display_on,
  output logic      [7:0]          display_ctrl,
  output logic      [7:0]          sys_ctrl,
  output logic      [7:0]          char_width,
  output logic      [7:0]          char_height,
  output logic      [7:0]          chars_per_row,
  output logic      [7:0]          total_per_row,
  output logic      [7:0]          lines_per_frame,
  output logic      [15:0]         addr_pitch,
  output logic      [15:0]         screen_start1,
  output logic      [15:0]         screen_start2,
  output logic      [15:0]         screen_start3,
  output logic      [15:0]         screen_start4,
  output logic      [7:0]          screen_lines1,
  output logic      [7:0]          screen_lines2,
  output logic      [15:0]         char_ram_base,
  output logic      [15:0]         cursor_shape,
  output logic      [1:0]          cursor_dir,
  output logic      [7:0]          pixel_hscroll,
  output logic      [7:0]          layer_mix
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (ADDR_W != `LCDC_ADDR_W) begin : g_bad_addr_w
    $error("lcdc_cmd_decoder: ADDR_W must be 16");
  end

  // ****************************************
  // command tracking
  // ****************************************
  lcdc_pkg::lcdc_cmd_t cur_cmd;
  lcdc_pkg::lcdc_cmd_t dec_cmd;
  logic [3:0]          dec_count;
  logic [3:0]          param_count;
  logic [3:0]          param_idx;
  logic [3:0]          rd_idx;
  logic [7:0]          pair_low;
  logic                cmd_wr;
  logic                param_wr;
  logic                slot_ok;
  logic                mem_access;
  logic [ADDR_W-1:0]   next_cursor;

  lcdc_opcode_decode u_decode (
    .opcode      (host_wdata),
    .cmd         (dec_cmd),
    .param_count (dec_count)
  );

  assign cmd_wr   = host_wr & cmd_param_select;
  assign param_wr = host_wr & ~cmd_param_select;
  assign slot_ok  = param_idx < param_count;

  // cursor step for the active direction
  function automatic logic [ADDR_W-1:0] step_cursor(
    input logic [ADDR_W-1:0] addr,
    input logic [1:0]        dir,
    input logic [15:0]       pitch
  );
    logic [ADDR_W-1:0] res;
    res = addr;
    unique case (dir)
      `LCDC_DIR_RIGHT: res = ADDR_W'(addr + 1'b1);
      `LCDC_DIR_LEFT:  res = ADDR_W'(addr - 1'b1);
      `LCDC_DIR_UP:    res = ADDR_W'(addr - pitch);
      `LCDC_DIR_DOWN:  res = ADDR_W'(addr + pitch);
    endcase
    return res;
  endfunction : step_cursor

  assign next_cursor = step_cursor(vram_addr, cursor_dir, addr_pitch);

  // ****************************************
  // command and slot counter
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur_cmd     <= lcdc_pkg::CMD_IDLE;
      param_count <= `LCDC_N_NONE;
      param_idx   <= `LCDC_N_NONE;
      rd_idx      <= `LCDC_N_NONE;
    end else if (cmd_wr) begin
      cur_cmd     <= dec_cmd;
      param_count <= dec_count;
      param_idx   <= `LCDC_N_NONE;
      rd_idx      <= `LCDC_N_NONE;
    end else begin
      if (param_wr && slot_ok && param_count != `LCDC_N_STREAM) begin
        param_idx <= 4'(param_idx + 1'b1);
      end
      if (host_rd && cur_cmd == lcdc_pkg::CMD_CURSOR_RD && rd_idx < `LCDC_N_TWO) begin
        rd_idx <= 4'(rd_idx + 1'b1);
      end
    end
  end

  // ****************************************
  // held low byte of a pair
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pair_low <= 8'h00;
    end else if (param_wr) begin
      pair_low <= host_wdata;
    end
  end

  // ****************************************
  // standby and display enable
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      standby      <= 1'b0;
      display_on   <= 1'b0;
      display_ctrl <= 8'h00;
    end else if (cmd_wr) begin
      if (dec_cmd == lcdc_pkg::CMD_STANDBY) begin
        standby <= 1'b1;
      end
      if (dec_cmd == lcdc_pkg::CMD_DISPLAY) begin
        display_on <= host_wdata[`LCDC_DISP_BIT];
      end
    end else if (param_wr && slot_ok) begin
      if (cur_cmd == lcdc_pkg::CMD_SYS_SETUP && param_idx == `LCDC_SYS_CTRL) begin
        standby    <= 1'b0;
        display_on <= 1'b0;
      end
      if (cur_cmd == lcdc_pkg::CMD_DISPLAY) begin
        display_ctrl <= host_wdata;
      end
    end
  end

  // ****************************************
  // setup registers
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sys_ctrl        <= 8'h00;
      char_width      <= 8'h00;
      char_height     <= 8'h00;
      chars_per_row   <= 8'h00;
      total_per_row   <= 8'h00;
      lines_per_frame <= 8'h00;
      addr_pitch      <= 16'h0000;
    end else if (param_wr && slot_ok && cur_cmd == lcdc_pkg::CMD_SYS_SETUP) begin
      unique case (param_idx)
        `LCDC_SYS_CTRL:   sys_ctrl        <= host_wdata;
        `LCDC_SYS_CWIDTH: char_width      <= host_wdata;
        `LCDC_SYS_CHGT:   char_height     <= host_wdata;
        `LCDC_SYS_CPR:    chars_per_row   <= host_wdata;
        `LCDC_SYS_TCPR:   total_per_row   <= host_wdata;
        `LCDC_SYS_LPF:    lines_per_frame <= host_wdata;
        `LCDC_SYS_PITCHL: addr_pitch[7:0] <= host_wdata;
        `LCDC_SYS_PITCHH: addr_pitch[15:8] <= host_wdata;
        default:          sys_ctrl        <= sys_ctrl;
      endcase
    end
  end

  // ****************************************
  // screen regions
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      screen_start1 <= 16'h0000;
      screen_start2 <= 16'h0000;
      screen_start3 <= 16'h0000;
      screen_start4 <= 16'h0000;
      screen_lines1 <= 8'h00;
      screen_lines2 <= 8'h00;
    end else if (param_wr && slot_ok && cur_cmd == lcdc_pkg::CMD_SCREEN_SETUP) begin
      unique case (param_idx)
        `LCDC_SCR_S1H: screen_start1 <= {host_wdata, pair_low};
        `LCDC_SCR_L1:  screen_lines1 <= host_wdata;
        `LCDC_SCR_S2H: screen_start2 <= {host_wdata, pair_low};
        `LCDC_SCR_L2:  screen_lines2 <= host_wdata;
        `LCDC_SCR_S3H: screen_start3 <= {host_wdata, pair_low};
        `LCDC_SCR_S4H: screen_start4 <= {host_wdata, pair_low};
        default:       screen_lines1 <= screen_lines1;
      endcase
    end
  end

  // ****************************************
  // one and two byte display settings
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      char_ram_base <= 16'h0000;
      cursor_shape  <= 16'h0000;
      pixel_hscroll <= 8'h00;
      layer_mix     <= 8'h00;
    end else if (param_wr && slot_ok) begin
      if (cur_cmd == lcdc_pkg::CMD_CHAR_RAM && param_idx == `LCDC_HI) begin
        char_ram_base <= {host_wdata, pair_low};
      end
      if (cur_cmd == lcdc_pkg::CMD_CURSOR_SHAPE) begin
        if (param_idx == `LCDC_LO) begin
          cursor_shape[7:0] <= host_wdata;
        end else begin
          cursor_shape[15:8] <= host_wdata;
        end
      end
      if (cur_cmd == lcdc_pkg::CMD_HSCROLL) begin
        pixel_hscroll <= host_wdata;
      end
      if (cur_cmd == lcdc_pkg::CMD_LAYER_MIX) begin
        layer_mix <= host_wdata;
      end
    end
  end

  // ****************************************
  // cursor direction
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cursor_dir <= `LCDC_DIR_RIGHT;
    end else if (cmd_wr && dec_cmd == lcdc_pkg::CMD_CURSOR_DIR) begin
      cursor_dir <= host_wdata[1:0];
    end
  end

  // ****************************************
  // cursor address
  // ****************************************
  // write steps after its pulse, so the byte lands at the cursor it was sent to
  assign mem_access = vram_we ||
                      (host_rd && cur_cmd == lcdc_pkg::CMD_VRAM_READ);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vram_addr <= '0;
    end else if (param_wr && slot_ok && cur_cmd == lcdc_pkg::CMD_CURSOR_WR) begin
      if (param_idx == `LCDC_LO) begin
        vram_addr[7:0] <= host_wdata;
      end else begin
        vram_addr[15:8] <= host_wdata;
      end
    end else if (mem_access) begin
      vram_addr <= next_cursor;
    end
  end

  // ****************************************
  // display memory write
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vram_we    <= 1'b0;
      vram_wdata <= 8'h00;
    end else begin
      vram_we <= param_wr && cur_cmd == lcdc_pkg::CMD_VRAM_WRITE;
      if (param_wr && cur_cmd == lcdc_pkg::CMD_VRAM_WRITE) begin
        vram_wdata <= host_wdata;
      end
    end
  end

  // ****************************************
  // host read data
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      host_rdata  <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        if (cur_cmd == lcdc_pkg::CMD_VRAM_READ) begin
          host_rdata <= vram_rdata;
        end else if (cur_cmd == lcdc_pkg::CMD_CURSOR_RD && rd_idx == `LCDC_LO) begin
          host_rdata <= vram_addr[7:0];
        end else if (cur_cmd == lcdc_pkg::CMD_CURSOR_RD && rd_idx == `LCDC_HI) begin
          host_rdata <= vram_addr[15:8];
        end else begin
          host_rdata <= 8'h00;
        end
      end
    end
  end

endmodule : lcdc_cmd_decoder

`default_nettype wire

// *** hdl/lcdc_consts.svh ***
// Purpose: named constants of the lcd command decoder
// Assumes: included by bare name
// Notes:   opcodes, parameter counts and slot numbers
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH

// ****************************************
// opcodes
// ****************************************
`define LCDC_OP_SYS_SETUP    8'h40
`define LCDC_OP_VRAM_WRITE   8'h42
`define LCDC_OP_VRAM_READ    8'h43
`define LCDC_OP_SCREEN_SETUP 8'h44
`define LCDC_OP_CURSOR_WR    8'h46
`define LCDC_OP_CURSOR_RD    8'h47
`define LCDC_OP_DIR_BASE     8'h4c
`define LCDC_OP_STANDBY      8'h53
`define LCDC_OP_DISP_BASE    8'h58
`define LCDC_OP_HSCROLL      8'h5a
`define LCDC_OP_LAYER_MIX    8'h5b
`define LCDC_OP_CHAR_RAM     8'h5c
`define LCDC_OP_CURSOR_SHAPE 8'h5d

// ****************************************
// parameter counts
// ****************************************
`define LCDC_N_SYS_SETUP    4'h8
`define LCDC_N_SCREEN_SETUP 4'ha
`define LCDC_N_TWO          4'h2
`define LCDC_N_ONE          4'h1
`define LCDC_N_NONE         4'h0
`define LCDC_N_STREAM       4'hf

// ****************************************
// parameter slots
// ****************************************
`define LCDC_SYS_CTRL   4'h0
`define LCDC_SYS_CWIDTH 4'h1
`define LCDC_SYS_CHGT   4'h2
`define LCDC_SYS_CPR    4'h3
`define LCDC_SYS_TCPR   4'h4
`define LCDC_SYS_LPF    4'h5
`define LCDC_SYS_PITCHL 4'h6
`define LCDC_SYS_PITCHH 4'h7
`define LCDC_SCR_S1L    4'h0
`define LCDC_SCR_S1H    4'h1
`define LCDC_SCR_L1     4'h2
`define LCDC_SCR_S2L    4'h3
`define LCDC_SCR_S2H    4'h4
`define LCDC_SCR_L2     4'h5
`define LCDC_SCR_S3L    4'h6
`define LCDC_SCR_S3H    4'h7
`define LCDC_SCR_S4L    4'h8
`define LCDC_SCR_S4H    4'h9
`define LCDC_LO         4'h0
`define LCDC_HI         4'h1

// ****************************************
// cursor directions and misc
// ****************************************
`define LCDC_DIR_RIGHT 2'h0
`define LCDC_DIR_LEFT  2'h1
`define LCDC_DIR_UP    2'h2
`define LCDC_DIR_DOWN  2'h3
`define LCDC_DISP_BIT  0
`define LCDC_ADDR_W    16

`endif

// *** hdl/lcdc_pkg.sv ***
// Purpose: types of the lcd command decoder
// Assumes: nothing
// Notes:   command state is one-hot
package lcdc_pkg;

  // ****************************************
  // active command
  // ****************************************
  typedef enum logic [13:0] {
    CMD_IDLE         = 14'h0001,
    CMD_SYS_SETUP    = 14'h0002,
    CMD_STANDBY      = 14'h0004,
    CMD_DISPLAY      = 14'h0008,
    CMD_SCREEN_SETUP = 14'h0010,
    CMD_CURSOR_SHAPE = 14'h0020,
    CMD_CHAR_RAM     = 14'h0040,
    CMD_CURSOR_DIR   = 14'h0080,
    CMD_HSCROLL      = 14'h0100,
    CMD_LAYER_MIX    = 14'h0200,
    CMD_CURSOR_WR    = 14'h0400,
    CMD_CURSOR_RD    = 14'h0800,
    CMD_VRAM_WRITE   = 14'h1000,
    CMD_VRAM_READ    = 14'h2000
  } lcdc_cmd_t;

endpackage : lcdc_pkg

// *** hdl/lcdc_opcode_decode.sv ***
// Purpose: maps a command byte to a command and its parameter count
// Assumes: purely combinational
// Notes:   unknown opcodes give the idle command
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_consts.svh"

module lcdc_opcode_decode (
  input  wire logic [7:0]         opcode,
  output lcdc_pkg::lcdc_cmd_t     cmd,
  output logic      [3:0]         param_count
);

  // ****************************************
  // decode
  // ****************************************
  always_comb begin
    cmd         = lcdc_pkg::CMD_IDLE;
    param_count = `LCDC_N_NONE;
    if (opcode == `LCDC_OP_SYS_SETUP) begin
      cmd         = lcdc_pkg::CMD_SYS_SETUP;
      param_count = `LCDC_N_SYS_SETUP;
    end else if (opcode == `LCDC_OP_STANDBY) begin
      cmd = lcdc_pkg::CMD_STANDBY;
    end else if (opcode[7:1] == `LCDC_OP_DISP_BASE >> 1) begin
      cmd         = lcdc_pkg::CMD_DISPLAY;
      param_count = `LCDC_N_ONE;
    end else if (opcode == `LCDC_OP_SCREEN_SETUP) begin
      cmd         = lcdc_pkg::CMD_SCREEN_SETUP;
      param_count = `LCDC_N_SCREEN_SETUP;
    end else if (opcode == `LCDC_OP_CURSOR_SHAPE) begin
      cmd         = lcdc_pkg::CMD_CURSOR_SHAPE;
      param_count = `LCDC_N_TWO;
    end else if (opcode == `LCDC_OP_CHAR_RAM) begin
      cmd         = lcdc_pkg::CMD_CHAR_RAM;
      param_count = `LCDC_N_TWO;
    end else if (opcode[7:2] == `LCDC_OP_DIR_BASE >> 2) begin
      cmd = lcdc_pkg::CMD_CURSOR_DIR;
    end else if (opcode == `LCDC_OP_HSCROLL) begin
      cmd         = lcdc_pkg::CMD_HSCROLL;
      param_count = `LCDC_N_ONE;
    end else if (opcode == `LCDC_OP_LAYER_MIX) begin
      cmd         = lcdc_pkg::CMD_LAYER_MIX;
      param_count = `LCDC_N_ONE;
    end else if (opcode == `LCDC_OP_CURSOR_WR) begin
      cmd         = lcdc_pkg::CMD_CURSOR_WR;
      param_count = `LCDC_N_TWO;
    end else if (opcode == `LCDC_OP_CURSOR_RD) begin
      cmd         = lcdc_pkg::CMD_CURSOR_RD;
      param_count = `LCDC_N_TWO;
    end else if (opcode == `LCDC_OP_VRAM_WRITE) begin
      cmd         = lcdc_pkg::CMD_VRAM_WRITE;
      param_count = `LCDC_N_STREAM;
    end else if (opcode == `LCDC_OP_VRAM_READ) begin
      cmd         = lcdc_pkg::CMD_VRAM_READ;
      param_count = `LCDC_N_STREAM;
    end
  end

endmodule : lcdc_opcode_decode

`default_nettype wire

// *** tb/lcdc_host_model.sv ***
// Purpose: host bus model of the lcd command decoder
// Assumes: one byte per strobe pulse
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module lcdc_host_model (
  input  wire logic       sys_clk,
  output logic            host_wr,
  output logic            host_rd,
  output logic            cmd_param_select,
  output logic      [7:0] host_wdata,
  output logic      [7:0] vram_rdata
);
  // ****************
  // bus cycles
  // ****************
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    cmd_param_select = 1'b0;
    host_wdata = 8'h00;
    vram_rdata = 8'hff;
  end

  task wr(input logic sel, input logic [7:0] dat);
    @(posedge sys_clk);
    host_wr          <= 1'b1;
    cmd_param_select <= sel;
    host_wdata       <= dat;
    @(posedge sys_clk);
    host_wr          <= 1'b0;
    host_wdata       <= ~dat;
    #1;
  endtask : wr

  task rd(input logic [7:0] dat);
    @(posedge sys_clk);
    host_rd    <= 1'b1;
    vram_rdata <= dat;
    @(posedge sys_clk);
    host_rd    <= 1'b0;
    vram_rdata <= ~dat;
    #1;
  endtask : rd
endmodule : lcdc_host_model
`default_nettype wire

// *** tb/lcdc_cmd_decoder_assertions.sv ***
// Purpose: port checker of the lcd command decoder
// Assumes: bound to the top module
// Notes:   single clock domain
`timescale 1ns/1ps
`default_nettype none
module lcdc_cmd_decoder_assertions (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic        cmd_param_select,
  input wire logic [7:0]  host_wdata,
  input wire logic        host_rvalid,
  input wire logic        vram_we,
  input wire logic [7:0]  vram_wdata,
  input wire logic        standby,
  input wire logic        display_on,
  input wire logic [1:0]  cursor_dir,
  input wire logic [15:0] char_ram_base,
  input wire logic [15:0] addr_pitch,
  input wire logic [7:0]  sys_ctrl,
  input wire logic [7:0]  pixel_hscroll,
  input wire logic [7:0]  layer_mix
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  wire cmd_wr = host_wr && cmd_param_select;
  wire par_wr = host_wr && !cmd_param_select;

  property p_rvalid;
    host_rvalid == $past(host_rd);
  endproperty
  property p_standby;
    cmd_wr && host_wdata == 8'h53 |=> standby;
  endproperty
  property p_disp;
    cmd_wr && host_wdata[7:1] == 7'h2c |=> display_on == $past(host_wdata[0]);
  endproperty
  property p_dir;
    cmd_wr && host_wdata[7:2] == 6'h13 |=> cursor_dir == $past(host_wdata[1:0]);
  endproperty
  property p_we;
    vram_we |-> $past(par_wr) && vram_wdata == $past(host_wdata);
  endproperty
  property p_pair;
    $changed(char_ram_base) |-> $past(par_wr) && char_ram_base[15:8] == $past(host_wdata);
  endproperty
  property p_pitch;
    $changed(addr_pitch[7:0]) |-> $stable(addr_pitch[15:8])
      && addr_pitch[7:0] == $past(host_wdata);
  endproperty
  property p_keep;
    $changed({sys_ctrl, pixel_hscroll, layer_mix}) |-> $past(par_wr);
  endproperty

  a_rvalid: assert property (p_rvalid)
    else $error("read answer not one cycle after strobe");
  a_standby: assert property (p_standby)
    else $error("standby not entered");
  a_disp: assert property (p_disp)
    else $error("display bit wrong");
  a_dir: assert property (p_dir)
    else $error("cursor direction wrong");
  a_we: assert property (p_we)
    else $error("memory write without data byte");
  a_pair: assert property (p_pair)
    else $error("char ram base changed off pair");
  a_pitch: assert property (p_pitch)
    else $error("pitch bytes not independent");
  a_keep: assert property (p_keep)
    else $error("setting changed without parameter");

  c_read: cover property (host_rvalid);
  c_write: cover property (vram_we);
  c_sleep: cover property ($rose(standby));
endmodule : lcdc_cmd_decoder_assertions

bind lcdc_cmd_decoder lcdc_cmd_decoder_assertions u_chk (
  .sys_clk, .reset, .host_wr, .host_rd, .cmd_param_select, .host_wdata,
  .host_rvalid, .vram_we, .vram_wdata, .standby, .display_on, .cursor_dir,
  .char_ram_base, .addr_pitch, .sys_ctrl, .pixel_hscroll, .layer_mix
);
`default_nettype wire

// *** tb/lcdc_cmd_decoder_tb_top.sv ***
// Purpose: self-checking bench of the lcd command decoder
// Assumes: host model drives the bus
// Notes:   reads and memory writes checked off queues
`timescale 1ns/1ps
`default_nettype none
module lcdc_cmd_decoder_tb_top;
  logic        sys_clk, reset, host_wr, host_rd, cmd_param_select;
  logic        host_rvalid, vram_we, standby, display_on;
  logic [1:0]  cursor_dir;
  logic [7:0]  host_wdata, vram_rdata, host_rdata, vram_wdata, display_ctrl;
  logic [7:0]  sys_ctrl, char_width, char_height, chars_per_row, total_per_row;
  logic [7:0]  lines_per_frame, screen_lines1, screen_lines2, pixel_hscroll;
  logic [7:0]  layer_mix, i, p, d;
  logic [15:0] vram_addr, addr_pitch, char_ram_base, cursor_shape;
  logic [15:0] screen_start1, screen_start2, screen_start3, screen_start4;
  logic [7:0]  e [10];
  logic [7:0]  rq [$];
  logic [7:0]  wq [$];
  logic [15:0] aq [$];
  int          seed = 31848;
  int          error_cnt = 0;
  int          checks_done = 0;

  lcdc_cmd_decoder #(.ADDR_W(16)) DUT (
    .sys_clk, .reset, .host_wr, .host_rd, .cmd_param_select, .host_wdata,
    .vram_rdata, .host_rdata, .host_rvalid, .vram_addr, .vram_wdata, .vram_we,
    .standby, .display_on, .display_ctrl, .sys_ctrl, .char_width, .char_height,
    .chars_per_row, .total_per_row, .lines_per_frame, .addr_pitch,
    .screen_start1, .screen_start2, .screen_start3, .screen_start4,
    .screen_lines1, .screen_lines2, .char_ram_base, .cursor_shape, .cursor_dir,
    .pixel_hscroll, .layer_mix
  );
  lcdc_host_model host (
    .sys_clk, .host_wr, .host_rd, .cmd_param_select, .host_wdata, .vram_rdata
  );

  // ****************
  // helpers
  // ****************
  always #2 sys_clk = ~sys_clk;

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task cmd(input logic [7:0] b);
    host.wr(1'b1, b);
  endtask : cmd

  task par(input logic [7:0] b);
    host.wr(1'b0, b);
  endtask : par

  function automatic logic [7:0] sys_reg(input logic [7:0] k);
    case (k)
      8'h0: sys_reg = sys_ctrl;
      8'h1: sys_reg = char_width;
      8'h2: sys_reg = char_height;
      8'h3: sys_reg = chars_per_row;
      8'h4: sys_reg = total_per_row;
      8'h5: sys_reg = lines_per_frame;
      8'h6: sys_reg = addr_pitch[7:0];
      default: sys_reg = addr_pitch[15:8];
    endcase
  endfunction : sys_reg

  always @(posedge sys_clk) begin
    if (host_rvalid === 1'b1) chk(host_rdata, rq.pop_front());
    if (vram_we === 1'b1) chk(vram_wdata, wq.pop_front());
    if (vram_we === 1'b1) chk(vram_addr, aq.pop_front());
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    wrap_up;
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    cmd(8'h53);
    chk(standby, 1'b1);
    for (p = 0; p < 2; p++) begin
      cmd(8'h40);
      for (i = 0; i < 8 - p; i++) begin
        e[i] = 8'($random(seed));
        par(e[i]);
        chk(sys_reg(i), e[i]);
      end
      chk(standby, 1'b0);
    end
    cmd(8'h5a);
    for (i = 0; i < 8; i++) chk(sys_reg(i), e[i]);
    $display("done setup");
    par(8'h3c);
    par(8'h77);
    chk(pixel_hscroll, 8'h3c);
    cmd(8'h5b);
    par(8'h1e);
    par(8'he1);
    chk(layer_mix, 8'h1e);
    for (i = 0; i < 4; i++) begin
      cmd(8'h58 | {7'h0, i[0]});
      par(8'h10 + i);
      chk(display_on, i[0]);
      chk(display_ctrl, 8'h10 + i);
    end
    for (i = 0; i < 4; i++) begin
      cmd(8'h4c + i);
      chk(cursor_dir, i[1:0]);
    end
    cmd(8'h5d);
    par(8'h07);
    par(8'h88);
    chk(cursor_shape, 16'h8807);
    cmd(8'h5d);
    par(8'h05);
    cmd(8'h4c);
    chk(cursor_shape, 16'h8805);
    $display("done single");
    cmd(8'h5c);
    par(8'h21);
    par(8'h43);
    chk(char_ram_base, 16'h4321);
    cmd(8'h44);
    for (i = 0; i < 10; i++) begin
      e[i] = 8'($random(seed));
      par(e[i]);
    end
    chk(screen_start1, {e[1], e[0]});
    chk(screen_lines1, e[2]);
    chk(screen_start2, {e[4], e[3]});
    chk(screen_lines2, e[5]);
    chk(screen_start3, {e[7], e[6]});
    chk(screen_start4, {e[9], e[8]});
    cmd(8'h5c);
    par(8'h99);
    cmd(8'h44);
    par(8'h5e);
    cmd(8'h4c);
    chk(char_ram_base, 16'h4321);
    chk(screen_start1, {e[1], e[0]});
    $display("done pairs");
    cmd(8'h46);
    par(8'h34);
    par(8'h12);
    cmd(8'h46);
    par(8'h56);
    chk(vram_addr, 16'h1256);
    cmd(8'h47);
    rq.push_back(8'h56);
    rq.push_back(8'h12);
    rq.push_back(8'h00);
    repeat (3) host.rd(8'($random(seed)));
    $display("done cursor");
    cmd(8'h42);
    for (i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      wq.push_back(d);
      aq.push_back(16'h1256 + 16'(i));
      par(d);
    end
    cmd(8'h4d);
    chk(vram_addr, 16'h1258);
    cmd(8'h43);
    for (i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      rq.push_back(d);
      host.rd(d);
    end
    chk(vram_addr, 16'h1256);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({15'h0, rq.size() == 0 && wq.size() == 0 && aq.size() == 0}, 16'h1);
    $display("done memory");
    wrap_up;
  end
endmodule : lcdc_cmd_decoder_tb_top
`default_nettype wire
